// [iacc_pkg.sv]
// constants and types for the i2c adc conversion control block
// Functional notes
// R01 - write-addressed command byte powers converter and starts a conversion
// R02 - acknowledge an address byte only on a match, else leave data line
// R03 - direction bit high makes device shift result bytes onto data line
// R04 - master reads results only after a conversion was commanded; bench reads once before any command
// R05 - each 12-bit result goes out as two bytes, bit 11 first
// R06 - upper byte: four zeros then bits 11..8; lower byte: bits 7..0
// R07 - master may use repeated start between results to keep the bus
// R08 - master keeps the link quiet for 3.7 us after repeated start
// R09 - converter powers as its bit arrives and needs 1.4 us to settle; code powers it only once the whole command byte is in
// R10 - internal reference is off after reset
// R11 - master sets reference bit in every command while reference is used
// R12 - reference turns on at stop or repeated start after command with bit set
// R13 - reference bit set while reference already on only keeps it on
// R14 - command byte with reference bit clear switches reference off
// R15 - master waits reference settling after each reference turn-on
// R16 - with external reference master clears reference bit and waits settle
// R17 - result holding register stays stable while a read frame runs
// R18 - address is fixed prefix, two strap bits, then direction bit
// R19 - command holds input mode, three channel bits, two power bits
// R20 - power bits choose converter and reference on or off
// R21 - acknowledge only after prefix, strap bits and direction bit arrived
package iacc_pkg;
    // bit counter inside one byte frame
    localparam logic [3:0] BIT_LAST    = 4'h7;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    // address byte layout
    localparam int         ADR_PFX_HI  = 7;
    localparam int         ADR_PFX_LO  = 3;
    localparam int         ADR_STRAP_H = 2;
    localparam int         ADR_STRAP_L = 1;
    localparam int         ADR_DIR     = 0;
    // command byte layout; bits 1..0 unused
    localparam int         CMD_MODE    = 7;
    localparam int         CMD_CH_HI   = 6;
    localparam int         CMD_CH_LO   = 4;
    localparam int         CMD_REF_PWR = 3;
    localparam int         CMD_CNV_PWR = 2;
    localparam logic [7:0] CMD_RESET   = 8'h00;
    // result layout
    localparam int         RES_W       = 12;
    localparam logic [3:0] RES_PAD     = 4'h0;
    localparam logic [11:0] RES_RESET  = 12'h000;
    // converter power-up time
    localparam int         CLK_PS      = 5000;
    localparam int         T_PWRUP_PS  = 1400000;
    localparam int         PWRUP_CYC   = (T_PWRUP_PS + CLK_PS - 1) / CLK_PS;
    localparam int         PWR_W       = 9;
    localparam logic [PWR_W-1:0] PWRUP_CNT = PWR_W'(PWRUP_CYC);

    typedef enum logic [1:0] {BUS_ADDR, BUS_WRITE, BUS_READ, BUS_IGNORE}
        iacc_bus_st_t;
    typedef enum logic [1:0] {LK_IDLE, LK_ARM, LK_RUN} iacc_link_st_t;

    function automatic logic iacc_addr_match(input logic [7:0] b,
                                             input logic [4:0] pfx,
                                             input logic [1:0] strap);
        return (b[ADR_PFX_HI:ADR_PFX_LO] == pfx) &&
               (b[ADR_STRAP_H] == strap[1]) && (b[ADR_STRAP_L] == strap[0]);
    endfunction
endpackage

// [iacc_top.sv]
// i2c slave front end and conversion control of the adc
`timescale 1ns/1ps
module iacc_top
    import iacc_pkg::*;
#(
    // five-bit address prefix; value is arbitrary
    parameter logic [4:0] ADDR_PREFIX = 5'h0b
) (
    // system
    input  wire logic              CLOCK,
    input  wire logic              RST,
    // i2c link
    input  wire logic              SCL,
    input  wire logic              SDA_I,
    output      logic              SDA_O,
    output      logic              SDA_OE,
    // address straps
    input  wire logic              ADDRESS_STRAP_LOW,
    input  wire logic              ADDRESS_STRAP_HIGH,
    // converter
    input  wire logic [RES_W-1:0]  RESULT,
    input  wire logic              RESULT_VALID,
    output      logic              CONV_START,
    output      logic [2:0]        CHANNEL,
    output      logic              INPUT_MODE_SELECT,
    output      logic              ADC_POWER,
    output      logic              ADC_READY,
    output      logic              REF_ON
);
    // pin synchronisers
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
    logic stl_m_q, stl_s_q, sth_m_q, sth_s_q;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            {scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q} <= 5'h1f;
        end else begin
            scl_m_q <= SCL;
            scl_s_q <= scl_m_q;
            sda_m_q <= SDA_I;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // straps keep moving through their synchroniser during reset, so the
    // capture on the first edge after release sees the real pin levels
    always_ff @(posedge CLOCK) begin
        stl_m_q <= ADDRESS_STRAP_LOW;
        stl_s_q <= stl_m_q;
        sth_m_q <= ADDRESS_STRAP_HIGH;
        sth_s_q <= sth_m_q;
    end

    logic start_c, stop_c;
    assign start_c = scl_s_q & sda_p_q & ~sda_s_q;
    assign stop_c  = scl_s_q & ~sda_p_q & sda_s_q;

    // core-domain state
    iacc_link_st_t    lk_q, lk_d;
    logic             hold_q, hold_d;
    logic [1:0]       strap_q, strap_d;
    logic             strap_ok_q, strap_ok_d;
    logic [2:0]       tg_q, tg_d;
    logic [7:0]       ctl_q, ctl_d;
    logic             start_q, start_d;
    logic             ref_on_q, ref_on_d, ref_pend_q, ref_pend_d;
    logic             busy_q, busy_d, ready_q, ready_d;
    logic [PWR_W-1:0] pwr_q, pwr_d;
    logic [RES_W-1:0] res_q, res_d, out_q, out_d;
    logic             cmd_evt;
    logic             tgl_q;
    logic [7:0]       cmd_q;

    assign cmd_evt = tg_q[2] ^ tg_q[1];

    always_comb begin
        lk_d       = lk_q;
        strap_d    = strap_q;
        strap_ok_d = 1'b1;
        tg_d       = {tg_q[1:0], tgl_q};
        ctl_d      = ctl_q;
        start_d    = 1'b0;
        ref_on_d   = ref_on_q;
        ref_pend_d = ref_pend_q;
        busy_d     = busy_q;
        res_d      = res_q;
        out_d      = out_q;
        if (start_c) begin
            lk_d = LK_ARM;
        end else if (stop_c) begin
            lk_d = LK_IDLE;
        end else if (lk_q == LK_ARM && !scl_s_q) begin
            lk_d = LK_RUN;
        end
        hold_d = (lk_d != LK_RUN);
        // R18 strap capture
        if (!strap_ok_q) begin
            strap_d = {sth_s_q, stl_s_q};
        end
        // R12 turn-on at bus condition
        if ((start_c || stop_c) && ref_pend_q) begin
            ref_on_d   = 1'b1;
            ref_pend_d = 1'b0;
        end
        if (cmd_evt) begin
            ctl_d = cmd_q;
            // R01 start conversion
            start_d = 1'b1;
            busy_d  = 1'b1;
            // R14 reference off
            if (!cmd_q[CMD_REF_PWR]) begin
                ref_on_d   = 1'b0;
                ref_pend_d = 1'b0;
            // R13 keep on only
            end else if (!ref_on_q) begin
                ref_pend_d = 1'b1;
            end
        end else if (RESULT_VALID) begin
            busy_d = 1'b0;
        end
        if (RESULT_VALID) begin
            res_d = RESULT;
        end
        // R17 update holding register only between frames
        if (hold_q) begin
            out_d = res_q;
        end
    end

    // R20 power bits steer converter
    assign ADC_POWER = ctl_q[CMD_CNV_PWR] | busy_q;

    // R09 power-up settle count
    always_comb begin
        pwr_d   = pwr_q;
        ready_d = 1'b0;
        if (!ADC_POWER) begin
            pwr_d = '0;
        end else if (pwr_q != PWRUP_CNT) begin
            pwr_d = pwr_q + PWR_W'(1);
        end else begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            lk_q       <= LK_IDLE;
            hold_q     <= 1'b1;
            strap_q    <= 2'h0;
            strap_ok_q <= 1'b0;
            tg_q       <= 3'h0;
            ctl_q      <= CMD_RESET;
            start_q    <= 1'b0;
            // R10 reference off at reset
            ref_on_q   <= 1'b0;
            ref_pend_q <= 1'b0;
            busy_q     <= 1'b0;
            ready_q    <= 1'b0;
            pwr_q      <= '0;
            res_q      <= RES_RESET;
            out_q      <= RES_RESET;
        end else begin
            lk_q       <= lk_d;
            hold_q     <= hold_d;
            strap_q    <= strap_d;
            strap_ok_q <= strap_ok_d;
            tg_q       <= tg_d;
            ctl_q      <= ctl_d;
            start_q    <= start_d;
            ref_on_q   <= ref_on_d;
            ref_pend_q <= ref_pend_d;
            busy_q     <= busy_d;
            ready_q    <= ready_d;
            pwr_q      <= pwr_d;
            res_q      <= res_d;
            out_q      <= out_d;
        end
    end

    assign CONV_START        = start_q;
    // R19 command fields out
    assign CHANNEL           = ctl_q[CMD_CH_HI:CMD_CH_LO];
    assign INPUT_MODE_SELECT = ctl_q[CMD_MODE];
    assign ADC_READY         = ready_q;
    assign REF_ON            = ref_on_q;

    // link domain, held in reset outside a running frame so that each
    // start restarts the byte framing without an scl edge of its own
    logic         link_rst;
    assign link_rst = RST | hold_q;

    iacc_bus_st_t st_q, st_d;
    logic [3:0]   cnt_q, cnt_d;
    logic [7:0]   sh_q, sh_d, cmd_d, tx_byte;
    logic         ack_q, ack_d, rw_q, rw_d, sel_q, sel_d, tgl_d;
    logic         oe_q, oe_d;
    logic [7:0]   rx_byte;

    assign rx_byte = {sh_q[6:0], SDA_I};
    // R06 upper byte padded with zeros
    assign tx_byte = sel_q ? out_q[7:0] : {RES_PAD, out_q[RES_W-1:8]};

    always_comb begin
        st_d  = st_q;
        cnt_d = '0;
        sh_d  = sh_q;
        ack_d = ack_q;
        rw_d  = rw_q;
        sel_d = sel_q;
        cmd_d = cmd_q;
        tgl_d = tgl_q;
        if (cnt_q != BIT_ACK) begin
            sh_d  = rx_byte;
            cnt_d = cnt_q + 4'h1;
        end
        if (cnt_q == BIT_LAST) begin
            // R21 judge only after direction bit
            if (st_q == BUS_ADDR) begin
                // R02 match check
                ack_d = iacc_addr_match(rx_byte, ADDR_PREFIX, strap_q);
                rw_d  = rx_byte[ADR_DIR];
            end else if (st_q == BUS_WRITE) begin
                ack_d = 1'b1;
                cmd_d = rx_byte;
                tgl_d = ~tgl_q;
            end
        end
        if (cnt_q == BIT_ACK) begin
            ack_d = 1'b0;
            if (st_q == BUS_ADDR) begin
                // R03 direction selects read
                st_d = !ack_q ? BUS_IGNORE : (rw_q ? BUS_READ : BUS_WRITE);
            end else if (st_q == BUS_READ) begin
                if (SDA_I) begin
                    st_d = BUS_IGNORE;
                end else begin
                    // R05 two bytes per result
                    sel_d = ~sel_q;
                end
            end
        end
    end

    always_ff @(posedge SCL or posedge link_rst) begin
        if (link_rst) begin
            st_q  <= BUS_ADDR;
            cnt_q <= 4'h0;
            sh_q  <= 8'h00;
            ack_q <= 1'b0;
            rw_q  <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
            ack_q <= ack_d;
            rw_q  <= rw_d;
            sel_q <= sel_d;
        end
    end

    // command word and its toggle survive frame resets
    always_ff @(posedge SCL or posedge RST) begin
        if (RST) begin
            cmd_q <= CMD_RESET;
            tgl_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            tgl_q <= tgl_d;
        end
    end

    // data line changes only while scl is low
    always_comb begin
        oe_d = (st_q == BUS_READ) && !tx_byte[3'(BIT_LAST - cnt_q)];
        if (cnt_q == BIT_ACK) begin
            oe_d = ack_q;
        end
    end

    always_ff @(negedge SCL or posedge link_rst) begin
        if (link_rst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    assign SDA_O  = 1'b0;
    assign SDA_OE = oe_q;

    property p_cmd_start;
        @(posedge CLOCK) disable iff (RST) cmd_evt |=> CONV_START && ADC_POWER;
    endproperty
    a_cmd_start: assert property (p_cmd_start) // R01
        else $error("command byte did not start a conversion");

    property p_ack_match;
        @(posedge SCL) disable iff (link_rst)
            (st_q == BUS_ADDR && cnt_q == BIT_ACK) |->
            (SDA_OE == iacc_addr_match(sh_q, ADDR_PREFIX, strap_q));
    endproperty
    a_ack_match: assert property (p_ack_match) // R02
        else $error("address acknowledge disagrees with match");

    property p_pad;
        @(posedge SCL) disable iff (link_rst)
            (st_q == BUS_READ && !sel_q && cnt_q < 4'h4) |-> SDA_OE;
    endproperty
    a_pad: assert property (p_pad) // R06
        else $error("upper byte lead bits not zero");

    property p_low_byte;
        @(posedge SCL) disable iff (link_rst)
            (st_q == BUS_READ && sel_q && cnt_q < BIT_ACK) |->
            (SDA_OE == !out_q[3'(BIT_LAST - cnt_q)]);
    endproperty
    a_low_byte: assert property (p_low_byte) // R05
        else $error("lower result byte bit wrong");

    property p_ref_turn_on;
        @(posedge CLOCK) disable iff (RST)
            $rose(ref_on_q) |->
            $past(ref_pend_q) && ($past(start_c) || $past(stop_c));
    endproperty
    a_ref_turn_on: assert property (p_ref_turn_on) // R12
        else $error("reference turned on without pending request");

    property p_ref_keep;
        @(posedge CLOCK) disable iff (RST)
            (cmd_evt && cmd_q[CMD_REF_PWR] && ref_on_q) |=>
            ref_on_q && !ref_pend_q;
    endproperty
    a_ref_keep: assert property (p_ref_keep) // R13
        else $error("reference restarted while on");

    property p_ref_off;
        @(posedge CLOCK) disable iff (RST)
            (cmd_evt && !cmd_q[CMD_REF_PWR]) |=> !ref_on_q [*2];
    endproperty
    a_ref_off: assert property (p_ref_off) // R14
        else $error("reference not switched off");

    property p_hold_stable;
        @(posedge CLOCK) disable iff (RST) !hold_q |=> $stable(out_q);
    endproperty
    a_hold_stable: assert property (p_hold_stable) // R17
        else $error("result holding register changed in a frame");

    property p_strap;
        @(posedge CLOCK) disable iff (RST) strap_ok_q |=> $stable(strap_q);
    endproperty
    a_strap: assert property (p_strap) // R18
        else $error("strap bits changed after startup");

    property p_ready;
        @(posedge CLOCK) disable iff (RST)
            $rose(ADC_POWER) |-> !ADC_READY [*8];
    endproperty
    a_ready: assert property (p_ready) // R09
        else $error("converter ready too early");

    c_ref_on: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(ref_on_q));
    c_cmd: cover property (@(posedge CLOCK) disable iff (RST) CONV_START);
    c_low_byte: cover property (@(posedge SCL) disable iff (link_rst)
        st_q == BUS_READ && sel_q && cnt_q == BIT_ACK);
    c_nack: cover property (@(posedge SCL) disable iff (link_rst)
        st_q == BUS_ADDR && cnt_q == BIT_ACK && !ack_q);
endmodule // iacc_top

// [iacc_master_model.sv]
// behavioural i2c bus master driving the adc link
`timescale 1ns/1ps
module iacc_master_model #(
    parameter int QNS   = 35,
    parameter int QUIET = 3700
) (
    // link
    output logic       scl,
    output logic       sda_pull,
    input  wire logic  sda,
    // each ack bit or read byte as it completes
    output logic [7:0] rx_byte,
    output logic       rx_stb
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
        rx_byte  = 8'h00;
        rx_stb   = 1'b0;
    end

    task automatic note(input logic [7:0] b);
        rx_byte = b;
        rx_stb  = 1'b1;
        #1 rx_stb = 1'b0;
    endtask

    // data moves only while the clock is low, a little after its fall
    task automatic bit_cyc(input logic b, output logic s);
        #2 sda_pull = ~b;
        #(QNS - 2) scl = 1'b1;
        #QNS s = sda;
        scl = 1'b0;
    endtask

    task automatic start(input logic rep);
        #2 sda_pull = 1'b0;
        #QNS scl = 1'b1;
        #QNS sda_pull = 1'b1;
        #QNS scl = 1'b0;
        if (rep) #QUIET;
    endtask

    // clock parks high between frames
    task automatic stop();
        #2 sda_pull = 1'b1;
        #QNS scl = 1'b1;
        #QNS sda_pull = 1'b0;
        #QNS;
    endtask

    task automatic wr_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
        bit_cyc(1'b1, s);
        note({7'h00, s});
    endtask

    // master acks all but the last byte
    task automatic rd_byte(input logic last);
        logic [7:0] v;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            v[i] = s;
        end
        bit_cyc(last, s);
        note(v);
    endtask
endmodule // iacc_master_model

// [tb_i2c_adc_conversion_control.sv]
// self-checking bench for the i2c adc conversion control block
`timescale 1ns/1ps
module tb_i2c_adc_conversion_control
    import iacc_pkg::*;
;
    // arbitrary prefix, handed to the design
    localparam logic [4:0] PFX  = 5'h0b;
    localparam int         WAIT = 300;

    logic             clock = 1'b0;
    logic             rst;
    logic             scl;
    logic             sda_pull;
    wire logic        sda;
    logic             sda_o;
    logic             sda_oe;
    logic             strap_lo;
    logic             strap_hi;
    logic [RES_W-1:0] result;
    logic             result_valid;
    logic             conv_start;
    logic [2:0]       channel;
    logic             in_mode;
    logic             adc_power;
    logic             adc_ready;
    logic             ref_on;
    logic [7:0]       rx_byte;
    logic             rx_stb;
    logic [RES_W-1:0] last_res;
    logic [RES_W-1:0] prev;
    logic [7:0]       cmd;
    logic [3:0]       e_cmd;
    logic             ref_m;
    integer           seed;
    integer           rnd;
    int               mismatches;
    int               check_count;
    int               cycles;
    logic [7:0]       exp_q[$];
    logic [3:0]       cmd_q[$];
    logic [7:0]       bad[3] = '{8'h80, 8'h04, 8'h02};

    // open-drain data line with pull-up
    assign sda = ~((sda_oe & ~sda_o) | sda_pull);

    always #2.5 clock = ~clock;

    iacc_top #(.ADDR_PREFIX(PFX)) u_dut (
        .CLOCK              (clock),
        .RST                (rst),
        .SCL                (scl),
        .SDA_I              (sda),
        .SDA_O              (sda_o),
        .SDA_OE             (sda_oe),
        .ADDRESS_STRAP_LOW  (strap_lo),
        .ADDRESS_STRAP_HIGH (strap_hi),
        .RESULT             (result),
        .RESULT_VALID       (result_valid),
        .CONV_START         (conv_start),
        .CHANNEL            (channel),
        .INPUT_MODE_SELECT  (in_mode),
        .ADC_POWER          (adc_power),
        .ADC_READY          (adc_ready),
        .REF_ON             (ref_on)
    );

    iacc_master_model u_m (
        .scl      (scl),
        .sda_pull (sda_pull),
        .sda      (sda),
        .rx_byte  (rx_byte),
        .rx_stb   (rx_stb)
    );

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // converter answers long after its start, past a short frame
    task automatic convert();
        repeat (200) @(negedge clock);
        rnd = $random(seed);
        result = rnd[RES_W-1:0];
        last_res = rnd[RES_W-1:0];
        result_valid = 1'b1;
        @(negedge clock) result_valid = 1'b0;
    endtask

    // outputs are looked at mid-cycle, where they have settled
    always @(negedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            conclude();
        end
        if (conv_start === 1'b1) begin
            fork
                convert();
            join_none
            e_cmd = (cmd_q.size() == 0) ? 4'hx : cmd_q.pop_front();
            check("cmd fields", {4'h0, in_mode, channel}, {4'h0, e_cmd});
        end
    end

    always @(posedge rx_stb) begin
        if (exp_q.size() == 0)
            check("stray byte", rx_byte, 8'hxx);
        else
            check("link byte", rx_byte, exp_q.pop_front());
    end

    function automatic logic [7:0] adr(input logic rd);
        return {PFX, strap_hi, strap_lo, rd};
    endfunction

    task automatic wr(input logic [7:0] b, input logic acked);
        exp_q.push_back({7'h00, ~acked});
        u_m.wr_byte(b);
    endtask

    task automatic command(input logic [7:0] c);
        u_m.start(1'b0);
        wr(adr(1'b0), 1'b1);
        cmd_q.push_back({c[7], c[6:4]});
        wr(c, 1'b1);
    endtask

    // padded upper byte, then lower byte
    task automatic read(input logic [11:0] r, input int n, input logic rep);
        u_m.start(rep);
        wr(adr(1'b1), 1'b1);
        for (int p = 0; p < n; p++) begin
            exp_q.push_back({RES_PAD, r[11:8]});
            u_m.rd_byte(1'b0);
            exp_q.push_back(r[7:0]);
            u_m.rd_byte(p == n - 1);
        end
        u_m.stop();
    endtask

    initial begin
        rst = 1'b1;
        result = '0;
        result_valid = 1'b0;
        last_res = '0;
        ref_m = 1'b0;
        seed = 32'hdad2;
        rnd = $random(seed);
        strap_lo = rnd[0];
        strap_hi = rnd[1];
        repeat (4) @(negedge clock);
        check("reset outs", {3'h0, ref_on, adc_power, adc_ready,
                             conv_start, sda_oe}, 8'h00);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        // wrong prefix or strap: no ack, command ignored
        for (int i = 0; i < 3; i++) begin
            u_m.start(1'b0);
            wr(adr(1'b0) ^ bad[i], 1'b0);
            wr(8'h0c, 1'b0);
            u_m.stop();
        end
        read(12'h000, 1, 1'b0);
        // every power mode, then reference back off
        for (int i = 0; i < 5; i++) begin
            rnd = $random(seed);
            cmd = {rnd[7:4], i[1:0], rnd[1:0]};
            command(cmd);
            @(negedge clock);
            check("ref pre stop", {7'h0, ref_on}, {7'h0, ref_m & cmd[3]});
            u_m.stop();
            ref_m = cmd[3];
            repeat (WAIT) @(negedge clock);
            check("ref on stop", {7'h0, ref_on}, {7'h0, ref_m});
            check("power", {6'h0, adc_power, adc_ready},
                  {6'h0, cmd[2], cmd[2]});
            read(last_res, 2, 1'b0);
        end
        // reference off, then turned on at repeated start by a command with the bit set
        rnd = $random(seed);
        cmd = {rnd[7:4], 2'b11, rnd[1:0]};
        prev = last_res;
        command(cmd);
        // result lands mid-frame, old one is read
        read(prev, 1, 1'b1);
        check("ref at sr", {7'h0, ref_on}, 8'h01);
        repeat (WAIT) @(negedge clock);
        read(last_res, 1, 1'b0);
        repeat (8) @(negedge clock);
        check("open notes", 8'(exp_q.size() + cmd_q.size()), 8'h00);
        conclude();
    end
endmodule // tb_i2c_adc_conversion_control
